/* include/drs_defines.svh */
/*
  Offsets, field positions, reset values and sizes of the reference
  selection block. Assumes inclusion by bare name from the design files.
*/
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define DRS_NCH 2
`define DRS_NREF 8
`define DRS_SYNC_W 13

// ----------------------------------------
// Register offsets within a channel window
// ----------------------------------------
`define DRS_OFF_MODE 6'h00
`define DRS_OFF_CTRL 6'h04
`define DRS_OFF_REFEN 6'h08
`define DRS_OFF_PRIO 6'h0C
`define DRS_OFF_CHOICE 6'h10
`define DRS_OFF_PSL 6'h14
`define DRS_OFF_FCAP 6'h18
`define DRS_OFF_STATUS 6'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DRS_CTRL_REVERT 0
`define DRS_CTRL_HS_EN 1
`define DRS_CTRL_HS_TYPE2 2
`define DRS_CTRL_PSL_EN 3
`define DRS_CTRL_PSL_UNLIM 4
`define DRS_CHOICE_FOL_LSB 8

// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define DRS_MODE_AUTO 4'h0
`define DRS_MODE_MAN_REG 4'h1
`define DRS_MODE_MAN_PIN 4'h2
`define DRS_MODE_FOLLOW 4'h3
`define DRS_MODE_PIN_FOLLOW 4'h4
`define DRS_RST_CTRL 5'h00
`define DRS_RST_REFEN 8'hFF
`define DRS_RST_PRIO 32'h76543210
`define DRS_RST_PSL 16'h0000
`define DRS_RST_FCAP 16'hFFFF

`endif

/* include/drs_pkg.sv */
/*
  Types shared by the reference selection modules.
  Assumes drs_defines.svh is on the include path.
*/
`include "drs_defines.svh"

package drs_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [2:0] drs_ref_t;
  typedef logic [3:0] drs_prio_t;

  typedef enum logic [2:0] {
    ST_FREE, LOCK_ACQUIRE_STATE, ST_LOCKED, ST_HOLD, ST_HITLESS,
    LOCK_RECOVER_STATE
  } drs_state_e;

  typedef enum logic [2:0] {
    MD_AUTO, MD_MAN_REG, MD_MAN_PIN, MD_FOLLOW
  } drs_mode_e;

  // Priority nibble of one input
  function automatic drs_prio_t drs_prio_of(input logic [31:0] tbl,
                                            input drs_ref_t idx);
    drs_prio_of = tbl[{idx, 2'b00} +: 4];
  endfunction : drs_prio_of

endpackage : drs_pkg

/* include/drs_pick_if.sv */
/*
  Carrier between the channel logic and its priority picker.
  Assumes drs_pkg compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

interface drs_pick_if;
  logic [7:0]  qual;
  logic [31:0] prio;
  logic [2:0]  cur;
  logic [2:0]  best;
  logic        any;
  modport picker (input qual, prio, cur, output best, any);
  modport user (output qual, prio, cur, input best, any);
endinterface : drs_pick_if

`default_nettype wire

/* hw/drs_priority_pick.sv */
/*
  Picks the best qualified input of one channel by priority.
  Assumes a lower priority value ranks higher and equal values form a group.
*/
`timescale 1ns/1ns
`default_nettype none
`include "drs_defines.svh"

module drs_priority_pick
  import drs_pkg::*;
(
  drs_pick_if.picker pick
);

  drs_ref_t  best;
  drs_prio_t bp;
  logic      hit;

  // ----------------------------------------
  // Highest rank among qualified inputs
  // ----------------------------------------
  always_comb begin
    best = pick.cur;
    bp   = 4'hF;
    hit  = 1'b0;
    for (int i = 0; i < `DRS_NREF; i++) begin
      if (pick.qual[i] && (!hit || drs_prio_of(pick.prio, 3'(i)) < bp)) begin
        best = 3'(i);
        bp   = drs_prio_of(pick.prio, 3'(i));
        hit  = 1'b1;
      end
    end
    if (hit && pick.qual[pick.cur] && drs_prio_of(pick.prio, pick.cur) == bp) begin
      best = pick.cur;
    end
    pick.best = best;
    pick.any  = hit;
  end

endmodule : drs_priority_pick

`default_nettype wire

/* hw/drs_reference_select.sv */
/*
  Reference selection and switchover control for two loop channels,
  with APB registers. Assumes monitors drive ref_valid asynchronously
  and the loop reports lock and phase measurement done on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "drs_defines.svh"

module drs_reference_select
  import drs_pkg::*;
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic [7:0]                       paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      pwdata,
  output logic [31:0]                           prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [`DRS_NREF-1:0]             ref_valid,
  input  wire logic [2:0]                       pin_manual_select_bit,
  input  wire logic [`DRS_NCH-1:0]              pin_follow,
  input  wire logic [`DRS_NCH-1:0]              dpll_locked,
  input  wire logic [`DRS_NCH-1:0]              phase_meas_done,
  output logic [`DRS_NCH-1:0][2:0]              ref_select,
  output logic [`DRS_NCH-1:0]                   ref_active,
  output logic [`DRS_NCH-1:0]                   holdover_alarm,
  output logic [`DRS_NCH-1:0]                   phase_measure_req,
  output logic [`DRS_NCH-1:0]                   offset_hold,
  output logic [`DRS_NCH-1:0]                   hitless_type2,
  output logic [`DRS_NCH-1:0]                   phase_rate_cap_en,
  output logic [`DRS_NCH-1:0]                   phase_rate_cap_unlim,
  output logic [`DRS_NCH-1:0][15:0]             phase_rate_cap_value,
  output logic [`DRS_NCH-1:0]                   freq_clamp_active,
  output logic [`DRS_NCH-1:0][15:0]             frequency_deviation_cap
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [3:0]          reference_mode_select [`DRS_NCH];
  logic [4:0]          channel_control_word  [`DRS_NCH];
  logic [7:0]          refen_q               [`DRS_NCH];
  logic [31:0]         input_priority_table  [`DRS_NCH];
  drs_ref_t            manual_reference_choice   [`DRS_NCH];
  drs_ref_t            follower_reference_choice [`DRS_NCH];
  logic [15:0]         psl_q                 [`DRS_NCH];
  logic [15:0]         fcap_q                [`DRS_NCH];
  drs_state_e          st_q                  [`DRS_NCH];
  drs_ref_t            sel_q                 [`DRS_NCH];
  logic [`DRS_SYNC_W-1:0] s1_q, s2_q, s3_q, stable_q;
  logic [7:0]          valid_s;
  drs_ref_t            pin_sel_s;
  logic [`DRS_NCH-1:0] fol_pin_s;
  drs_pick_if pif [`DRS_NCH] ();
  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      stable_q <= '0;
    end else begin
      s1_q <= {pin_follow, pin_manual_select_bit, ref_valid};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        stable_q <= s3_q;
      end
    end
  end
  assign valid_s   = stable_q[7:0];
  assign pin_sel_s = stable_q[10:8];
  assign fol_pin_s = stable_q[12:11];
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function automatic drs_mode_e mode_of(input logic [3:0] code,
                                        input logic fol_pin);
    case (code)
      `DRS_MODE_MAN_REG:    mode_of = MD_MAN_REG;
      `DRS_MODE_MAN_PIN:    mode_of = MD_MAN_PIN;
      `DRS_MODE_FOLLOW:     mode_of = MD_FOLLOW;
      `DRS_MODE_PIN_FOLLOW: mode_of = fol_pin ? MD_FOLLOW : MD_AUTO;
      default:              mode_of = MD_AUTO;
    endcase
  endfunction : mode_of
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[7:6] < 2'(`DRS_NCH)) && (a[1:0] == 2'b00) && (a[5] == 1'b0);
  endfunction : addr_ok
  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [1:0] ach;
  logic [5:0] aoff;
  logic       wr_en;
  assign ach     = paddr[7:6];
  assign aoff    = paddr[5:0];
  assign pready  = 1'b1;
  assign pslverr = psel && penable &&
                   (!addr_ok(paddr) || (pwrite && aoff == `DRS_OFF_STATUS));
  assign wr_en   = psel && penable && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < `DRS_NCH; c++) begin
        reference_mode_select[c]     <= `DRS_MODE_AUTO;
        channel_control_word[c]      <= `DRS_RST_CTRL;
        refen_q[c]                   <= `DRS_RST_REFEN;
        input_priority_table[c]      <= `DRS_RST_PRIO;
        manual_reference_choice[c]   <= '0;
        follower_reference_choice[c] <= '0;
        psl_q[c]                     <= `DRS_RST_PSL;
        fcap_q[c]                    <= `DRS_RST_FCAP;
      end
    end else if (wr_en) begin
      for (int c = 0; c < `DRS_NCH; c++) begin
        if (ach == 2'(c)) begin
          case (aoff)
            `DRS_OFF_MODE:  reference_mode_select[c] <= pwdata[3:0];
            `DRS_OFF_CTRL:  channel_control_word[c]  <= pwdata[4:0];
            `DRS_OFF_REFEN: refen_q[c]               <= pwdata[7:0];
            `DRS_OFF_PRIO:  input_priority_table[c]  <= pwdata;
            `DRS_OFF_CHOICE: begin
              manual_reference_choice[c]   <= pwdata[2:0];
              follower_reference_choice[c] <= pwdata[`DRS_CHOICE_FOL_LSB +: 3];
            end
            `DRS_OFF_PSL:   psl_q[c]  <= pwdata[15:0];
            `DRS_OFF_FCAP:  fcap_q[c] <= pwdata[15:0];
            default: ;
          endcase
        end
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      for (int c = 0; c < `DRS_NCH; c++) begin
        if (ach == 2'(c) && addr_ok(paddr)) begin
          case (aoff)
            `DRS_OFF_MODE:   prdata <= {28'h0000000, reference_mode_select[c]};
            `DRS_OFF_CTRL:   prdata <= {27'h0000000, channel_control_word[c]};
            `DRS_OFF_REFEN:  prdata <= {24'h000000, refen_q[c]};
            `DRS_OFF_PRIO:   prdata <= input_priority_table[c];
            `DRS_OFF_CHOICE: prdata <= {21'h000000, follower_reference_choice[c],
                                        5'h00, manual_reference_choice[c]};
            `DRS_OFF_PSL:    prdata <= {16'h0000, psl_q[c]};
            `DRS_OFF_FCAP:   prdata <= {16'h0000, fcap_q[c]};
            `DRS_OFF_STATUS: prdata <= {23'h000000, holdover_alarm[c],
                                        ref_active[c], 1'b0, st_q[c], sel_q[c]};
            default:         prdata <= '0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Per-channel selection and state machine
  // ----------------------------------------
  for (genvar g = 0; g < `DRS_NCH; g++) begin : g_ch
    drs_mode_e md;
    drs_ref_t  cand;
    logic      ok;
    logic      cur_ok;
    logic      revert;
    logic      hs_en;
    logic [7:0] qual;
    drs_priority_pick drs_priority_pick_inst (
      .pick (pif[g])
    );
    assign revert = channel_control_word[g][`DRS_CTRL_REVERT];
    assign hs_en  = channel_control_word[g][`DRS_CTRL_HS_EN];
    assign qual   = refen_q[g] & valid_s;
    assign pif[g].qual = qual;
    assign pif[g].prio = input_priority_table[g];
    assign pif[g].cur  = sel_q[g];
    always_comb begin
      md     = mode_of(reference_mode_select[g], fol_pin_s[g]);
      cur_ok = qual[sel_q[g]];
      cand   = pif[g].best;
      ok     = pif[g].any;
      case (md)
        MD_MAN_REG: begin
          cand = manual_reference_choice[g];
          ok   = valid_s[cand];
        end
        MD_MAN_PIN: begin
          cand = pin_sel_s;
          ok   = valid_s[cand];
        end
        MD_FOLLOW: begin
          cand = follower_reference_choice[g];
          ok   = valid_s[cand];
        end
        default: begin
          if (cur_ok && !revert) begin
            cand = sel_q[g];
          end else if (cur_ok && !(drs_prio_of(input_priority_table[g], pif[g].best) <
                                  drs_prio_of(input_priority_table[g], sel_q[g]))) begin
            cand = sel_q[g];
          end
        end
      endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q[g]  <= ST_FREE;
        sel_q[g] <= '0;
      end else begin
        case (st_q[g])
          ST_FREE: begin
            if (ok) begin
              st_q[g]  <= LOCK_ACQUIRE_STATE;
              sel_q[g] <= cand;
            end
          end
          LOCK_ACQUIRE_STATE: begin
            if (!ok) begin
              st_q[g] <= ST_FREE;
            end else if (cand != sel_q[g]) begin
              sel_q[g] <= cand;
            end else if (dpll_locked[g]) begin
              st_q[g] <= ST_LOCKED;
            end
          end
          ST_LOCKED, LOCK_RECOVER_STATE: begin
            if (!ok) begin
              st_q[g] <= ST_HOLD;
            end else if (cand != sel_q[g]) begin
              sel_q[g] <= cand;
              st_q[g]  <= hs_en ? ST_HITLESS : LOCK_RECOVER_STATE;
            end else if (dpll_locked[g]) begin
              st_q[g] <= ST_LOCKED;
            end
          end
          ST_HOLD: begin
            if (ok) begin
              sel_q[g] <= cand;
              st_q[g]  <= hs_en ? ST_HITLESS : LOCK_RECOVER_STATE;
            end
          end
          ST_HITLESS: begin
            if (!ok) begin
              st_q[g] <= ST_HOLD;
            end else if (phase_meas_done[g]) begin
              st_q[g] <= LOCK_RECOVER_STATE;
            end
          end
          default: st_q[g] <= ST_FREE;
        endcase
      end
    end

    // Loop-facing outputs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        holdover_alarm[g]    <= 1'b0;
        phase_measure_req[g] <= 1'b0;
        offset_hold[g]       <= 1'b0;
        ref_active[g]        <= 1'b0;
        freq_clamp_active[g] <= 1'b0;
      end else begin
        holdover_alarm[g]    <= (st_q[g] == ST_HOLD);
        phase_measure_req[g] <= (st_q[g] == ST_HITLESS) && hs_en &&
                                (ref_active[g] || holdover_alarm[g]);
        ref_active[g]        <= (st_q[g] == LOCK_ACQUIRE_STATE) ||
                                (st_q[g] == ST_LOCKED) || (st_q[g] == LOCK_RECOVER_STATE);
        freq_clamp_active[g] <= (st_q[g] != ST_FREE) && (st_q[g] != ST_LOCKED);
        if (st_q[g] == ST_HITLESS && phase_meas_done[g] && ok) begin
          offset_hold[g] <= 1'b1;
        end else if (st_q[g] == ST_HITLESS || st_q[g] == ST_FREE) begin
          offset_hold[g] <= 1'b0;
        end
      end
    end
    assign ref_select[g]              = sel_q[g];
    assign hitless_type2[g]           = channel_control_word[g][`DRS_CTRL_HS_TYPE2];
    assign phase_rate_cap_en[g]       = channel_control_word[g][`DRS_CTRL_PSL_EN];
    assign phase_rate_cap_unlim[g]    = channel_control_word[g][`DRS_CTRL_PSL_UNLIM];
    assign phase_rate_cap_value[g]    = psl_q[g];
    assign frequency_deviation_cap[g] = fcap_q[g];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence seq_locked_loss;
      st_q[g] == ST_LOCKED && !ok;
    endsequence
    sequence seq_enter_hitless;
      st_q[g] != ST_HITLESS ##1 st_q[g] == ST_HITLESS;
    endsequence
    AST_FREE_TO_ACQ: assert property (
      st_q[g] == ST_FREE && ok |=> st_q[g] == LOCK_ACQUIRE_STATE && sel_q[g] == $past(cand))
      else $error("free-run did not start acquisition");
    AST_LOSS_HOLD: assert property (
      seq_locked_loss |=> st_q[g] == ST_HOLD ##1 holdover_alarm[g])
      else $error("loss of reference did not raise holdover");
    AST_MANUAL_PICK: assert property (
      md == MD_MAN_REG && st_q[g] == ST_FREE && valid_s[manual_reference_choice[g]]
      |=> sel_q[g] == $past(manual_reference_choice[g]))
      else $error("manual choice not followed");
    AST_NONREVERT_HOLD: assert property (
      md == MD_AUTO && !revert && st_q[g] == ST_LOCKED && cur_ok |=> $stable(sel_q[g]))
      else $error("non-revertive switch without loss");
    AST_REVERT_MOVE: assert property (
      md == MD_AUTO && revert && st_q[g] == ST_LOCKED && cur_ok &&
      drs_prio_of(input_priority_table[g], pif[g].best) <
      drs_prio_of(input_priority_table[g], sel_q[g])
      |=> sel_q[g] == $past(pif[g].best))
      else $error("revertive switch missed");
    AST_HITLESS_ENTRY: assert property (
      hs_en && st_q[g] == ST_LOCKED && ok && cand != sel_q[g] |=> st_q[g] == ST_HITLESS)
      else $error("hitless switch not started");
    AST_HITLESS_NO_ALARM: assert property (
      seq_enter_hitless |=> !holdover_alarm[g])
      else $error("holdover alarm during hitless switch");
    AST_MEASURE_REQ: assert property (
      seq_enter_hitless |=> phase_measure_req[g] ##1 !phase_measure_req[g])
      else $error("phase measurement not requested once");
    AST_OFFSET_KEEP: assert property (
      st_q[g] == ST_HITLESS && ok && phase_meas_done[g]
      |=> st_q[g] == LOCK_RECOVER_STATE && offset_hold[g])
      else $error("measured offset not kept");
    AST_FOLLOWER: assert property (
      md == MD_FOLLOW && st_q[g] == ST_FREE && ok
      |=> sel_q[g] == $past(follower_reference_choice[g]))
      else $error("follower input not used");
  end
endmodule : drs_reference_select

`default_nettype wire

/* tb/drs_ref_partner.sv */
/*
  Model of the reference monitors, selection pins and loop lock report.
  Assumes the bench drives the commands on rising pclk edges.
*/
`timescale 1ns/1ns
`default_nettype none

module drs_ref_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic [7:0] valid_cmd,
  input  wire logic [2:0] pin_cmd,
  input  wire logic [1:0] follow_cmd,
  input  wire logic [1:0] ref_active,
  input  wire logic [1:0] phase_measure_req,
  output logic [7:0]      ref_valid,
  output logic [2:0]      pin_manual_select_bit,
  output logic [1:0]      pin_follow,
  output logic [1:0]      dpll_locked,
  output logic [1:0]      phase_meas_done
);
  // ----------------------------------------
  // Monitors, pins, loop
  // ----------------------------------------
  logic [3:0] lock_q [2];
  logic [1:0] meas_q [2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_valid             <= 8'h00;
      pin_manual_select_bit <= 3'h0;
      pin_follow            <= 2'h0;
    end else begin
      ref_valid             <= valid_cmd;
      pin_manual_select_bit <= pin_cmd;
      pin_follow            <= follow_cmd;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_loop
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lock_q[c] <= 4'h0;
        meas_q[c] <= 2'h0;
      end else begin
        lock_q[c] <= ref_active[c] ? lock_q[c] + 4'(lock_q[c] != 4'hF) : 4'h0;
        meas_q[c] <= phase_measure_req[c] ? 2'h3 : meas_q[c] - 2'(meas_q[c] != 2'h0);
      end
    end
    assign dpll_locked[c]     = lock_q[c] >= (slow ? 4'hC : 4'h2);
    assign phase_meas_done[c] = meas_q[c] == 2'h1;
  end
endmodule : drs_ref_partner

`default_nettype wire

/* tb/drs_reference_select_tb.sv */
/*
  Self-checking bench of the reference selection block over APB.
  Assumes drs_pkg, drs_pick_if and the design are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "drs_defines.svh"

module drs_reference_select_tb;
  import drs_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic             slow = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [7:0]       valid_cmd = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      rd;
  logic [2:0]       pin_cmd = 3'h0;
  logic [1:0]       follow_cmd = 2'h0;
  logic [31:0]      prdata;
  logic             pready, pslverr;
  logic [7:0]       ref_valid;
  logic [2:0]       pin_manual_select_bit;
  logic [1:0]       pin_follow, dpll_locked, phase_meas_done, ref_active;
  logic [1:0]       holdover_alarm, phase_measure_req, offset_hold, hitless_type2;
  logic [1:0]       phase_rate_cap_en, phase_rate_cap_unlim, freq_clamp_active;
  logic [1:0][2:0]  ref_select;
  logic [1:0][15:0] phase_rate_cap_value, frequency_deviation_cap;
  int               num_errors = 0;
  int               checks = 0;
  int               req_seen = 0;

  always #10 pclk = ~pclk;

  drs_reference_select drs_reference_select_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .ref_valid, .pin_manual_select_bit, .pin_follow, .dpll_locked,
    .phase_meas_done, .ref_select, .ref_active, .holdover_alarm, .phase_measure_req,
    .offset_hold, .hitless_type2, .phase_rate_cap_en, .phase_rate_cap_unlim,
    .phase_rate_cap_value, .freq_clamp_active, .frequency_deviation_cap);

  drs_ref_partner drs_ref_partner_inst (
    .pclk, .presetn, .slow, .valid_cmd, .pin_cmd, .follow_cmd, .ref_active,
    .phase_measure_req, .ref_valid, .pin_manual_select_bit, .pin_follow,
    .dpll_locked, .phase_meas_done);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", pready, 1'b1);
      close_out();
    end
    rd = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [1:0] ch, input logic [5:0] off, input logic [31:0] d);
    logic e;
    apb(1'b1, {ch, off}, d, e);
  endtask : wr

  task automatic rdc(input logic [1:0] ch, input logic [5:0] off, input logic [31:0] x,
                     input string nm);
    logic e;
    apb(1'b0, {ch, off}, 32'h0, e);
    chk(nm, rd, x);
  endtask : rdc

  task automatic wait_st(input logic [1:0] ch, input drs_state_e st, input logic [2:0] s);
    logic e;
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, {ch, `DRS_OFF_STATUS}, 32'h0, e);
      if (rd[5:0] === {st, s}) break;
    end
    chk("status", rd[5:0], {st, s});
    if (rd[5:0] !== {st, s}) close_out();
  endtask : wait_st

  always @(posedge pclk) begin
    if (phase_measure_req[0] === 1'b1) begin
      req_seen <= req_seen + 1;
      chk("alarm in hitless", holdover_alarm[0], 1'b0);
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic e;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(0, `DRS_OFF_STATUS, 32'h0, "status");
    rdc(0, `DRS_OFF_CTRL, 32'h0, "ctrl");
    rdc(0, `DRS_OFF_REFEN, 32'hFF, "refen");
    rdc(0, `DRS_OFF_PRIO, `DRS_RST_PRIO, "prio");
    rdc(1, `DRS_OFF_FCAP, 32'hFFFF, "fcap");
    apb(1'b0, 8'h80, 32'h0, e);
    chk("bad addr", e, 1'b1);
    apb(1'b1, {2'd0, `DRS_OFF_STATUS}, 32'h0, e);
    chk("ro write", e, 1'b1);
    valid_cmd <= 8'hFF;
    wait_st(0, ST_LOCKED, 0);
    wr(0, `DRS_OFF_REFEN, 32'hFE);
    wait_st(0, ST_LOCKED, 1);
    wr(0, `DRS_OFF_REFEN, 32'hFF);
    repeat (12) @(posedge pclk);
    wait_st(0, ST_LOCKED, 1);
    wr(0, `DRS_OFF_CTRL, 32'h1);
    wait_st(0, ST_LOCKED, 0);
    wr(0, `DRS_OFF_PRIO, 32'h76543200);
    valid_cmd <= 8'hFE;
    wait_st(0, ST_LOCKED, 1);
    valid_cmd <= 8'hFF;
    repeat (12) @(posedge pclk);
    wait_st(0, ST_LOCKED, 1);
    slow <= 1'b1;
    pin_cmd <= 3'h5;
    wr(0, `DRS_OFF_CHOICE, 32'h602);
    wr(0, `DRS_OFF_MODE, `DRS_MODE_MAN_REG);
    wait_st(0, ST_LOCKED, 2);
    valid_cmd <= 8'hFB;
    wait_st(0, ST_HOLD, 2);
    chk("alarm", holdover_alarm[0], 1'b1);
    chk("clamp", freq_clamp_active[0], 1'b1);
    wr(0, `DRS_OFF_CTRL, 32'h3);
    valid_cmd <= 8'hFF;
    wait_st(0, ST_LOCKED, 2);
    chk("offset", offset_hold[0], 1'b1);
    wr(0, `DRS_OFF_MODE, `DRS_MODE_MAN_PIN);
    wait_st(0, ST_LOCKED, 5);
    chk("measure", req_seen, 2);
    wr(0, `DRS_OFF_MODE, `DRS_MODE_FOLLOW);
    wait_st(0, ST_LOCKED, 6);
    valid_cmd <= 8'hBF;
    wait_st(0, ST_HOLD, 6);
    valid_cmd <= 8'hFF;
    wr(1, `DRS_OFF_CHOICE, 32'h700);
    wr(1, `DRS_OFF_MODE, `DRS_MODE_PIN_FOLLOW);
    follow_cmd <= 2'b10;
    wait_st(1, ST_LOCKED, 7);
    wait_st(0, ST_LOCKED, 6);
    wr(0, `DRS_OFF_MODE, 32'hF);
    wait_st(0, ST_LOCKED, 0);
    chk("ref_select", ref_select[0], 3'h0);
    chk("active", ref_active[0], 1'b1);
    chk("clamp locked", freq_clamp_active[0], 1'b0);
    wr(1, `DRS_OFF_CTRL, 32'h1C);
    wr(1, `DRS_OFF_PSL, 32'hFFFF);
    wr(1, `DRS_OFF_FCAP, 32'h1234);
    repeat (2) @(posedge pclk);
    chk("ctl", {hitless_type2[1], phase_rate_cap_en[1], phase_rate_cap_unlim[1]}, 3'h7);
    chk("psl", phase_rate_cap_value[1], 16'hFFFF);
    chk("fcap", frequency_deviation_cap[1], 16'h1234);
    close_out();
  end
endmodule : drs_reference_select_tb

`default_nettype wire
